/* fcdma_top.sv */
// Purpose: Four-channel cycle-steal DMA controller.
// Assumes: All inputs synchronous to clock; bus arbiter outside.
// Notes:   One unit per granted bus tenure, then the bus goes back.
// How it works
// - Four channels; each accepted request moves exactly one unit.
// - Bus request goes high when the sequencer is idle and a channel is ready.
// - Per-channel wide bit picks byte or word for every unit.
// - Five-bit source code; code zero plus software bit starts transfer.
// - Codes map to pin falling, both edges, then peripheral requests.
// - Peripheral requests trigger regardless of processor masking.
// - Every peripheral request, selected or not, sets its flag; transfer never clears it.
// - 24-bit addresses; exactly one side fixed, other increments.
// - Incremented address steps by unit size; fixed stays.
// - Sixteen-bit unit counter.
// - Mode 00 off, 01 single, 11 repeat; 00 stops at once.
// - Start only when enabled and count is nonzero.
// - Single mode decrements and stops at zero or written zero.
// - Repeat mode reloads count at zero and keeps serving.
// - Repeat mode reloads moving pointer when count goes one to zero.
// - Repeat stops when disabled or count and reload both zero.
// - Channel interrupt pulses only on count one to zero.
// - Fixed priority: channel 0 highest, channel 3 lowest.
// - A unit takes at least three clock cycles.
// - After a unit, wait one processor access before next grant.
// - One pending flag per channel, cleared when bus is taken.
// - Requests sampled each clock; same-cycle requests set together.
`timescale 1ns/100ps
module fcdma_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] ext_irq_pin,
  input wire logic [21:0] periph_req,
  output logic [21:0] periph_ir_set,
  output logic bus_req,
  input wire logic bus_gnt,
  input wire logic cpu_access_done,
  output fcdma_pkg::fcdma_mem_t mem_req,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [3:0] dma_irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic src_hit(input logic [4:0] code,
                                   input logic sw,
                                   input logic fall,
                                   input logic rise,
                                   input logic [21:0] pr);
    logic [4:0] k;
    k = code - fcdma_pkg::CODE_PERIPH0;
    if (code == fcdma_pkg::CODE_SW) begin
      src_hit = sw;
    end else if (code == fcdma_pkg::CODE_FALL) begin
      src_hit = fall;
    end else if (code == fcdma_pkg::CODE_BOTH) begin
      src_hit = fall | rise;
    end else if (code <= fcdma_pkg::CODE_LAST) begin
      src_hit = pr[k];
    end else begin
      src_hit = 1'b0;
    end
  endfunction

  function automatic logic [23:0] unit_step(input logic wide);
    unit_step = wide ? 24'h000002 : 24'h000001;
  endfunction

  function automatic logic [1:0] pick_first(input logic [3:0] rdy);
    if (rdy[0]) begin
      pick_first = 2'h0;
    end else if (rdy[1]) begin
      pick_first = 2'h1;
    end else if (rdy[2]) begin
      pick_first = 2'h2;
    end else begin
      pick_first = 2'h3;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [23:0] src_ff [4];
  logic [23:0] dst_ff [4];
  logic [23:0] rld_ptr_ff [4];
  logic [15:0] cnt_ff [4];
  logic [15:0] rld_cnt_ff [4];
  logic [4:0] code_ff [4];
  logic [1:0] mode_ff [4];
  logic [3:0] pend_ff, wide_ff, dinc_ff;
  logic [23:0] nxt_src [4];
  logic [23:0] nxt_dst [4];
  logic [23:0] nxt_rld_ptr [4];
  logic [15:0] nxt_cnt [4];
  logic [15:0] nxt_rld_cnt [4];
  logic [4:0] nxt_code [4];
  logic [1:0] nxt_mode [4];
  logic [3:0] nxt_pend, nxt_wide, nxt_dinc, nxt_irq;
  logic [15:0] eff [4];
  logic [3:0] en, ready, hit, sw_hit, fall, rise;
  logic [3:0] pin_prev_ff, irq_ff;
  fcdma_pkg::fcdma_state_t state_ff, nxt_state;
  fcdma_pkg::fcdma_mem_t mem_ff, nxt_mem;
  logic [1:0] cur_ff, pick;
  logic [31:0] rdata_ff, rd_val;
  logic [21:0] ir_set_ff;
  logic take, done;
  logic [1:0] wch;
  logic [2:0] wreg;
  logic [15:0] eff_cur;

  // ----------------------------------------------------------------
  // Request sampling and arbitration
  // ----------------------------------------------------------------
  // Pins are active low, so a falling edge is the asserting one.
  assign fall = pin_prev_ff & ~ext_irq_pin;
  assign rise = ~pin_prev_ff & ext_irq_pin;
  assign wch = reg_addr[4:3];
  assign wreg = reg_addr[2:0];
  assign take = (state_ff == fcdma_pkg::ST_IDLE) & bus_gnt & bus_req;
  assign done = (state_ff == fcdma_pkg::ST_PAD);
  assign pick = pick_first(ready);
  assign bus_req = (state_ff == fcdma_pkg::ST_IDLE) & (|ready);
  assign eff_cur = eff[cur_ff];

  always_comb begin
    for (int i = 0; i < fcdma_pkg::NCH; i++) begin
      sw_hit[i] = reg_wr & (wch == 2'(i)) & (wreg == fcdma_pkg::REG_SEL)
                  & reg_wdata[fcdma_pkg::SEL_SW_BIT];
      // Processor masks never reach here, only raw requests.
      hit[i] = src_hit(code_ff[i], sw_hit[i], fall[i], rise[i],
                       periph_req);
      en[i] = (mode_ff[i] == fcdma_pkg::MODE_SINGLE) |
              (mode_ff[i] == fcdma_pkg::MODE_REPEAT);
      // A repeat channel left at zero with a nonzero reload restarts.
      eff[i] = ((cnt_ff[i] == fcdma_pkg::RST_CNT) &&
                (mode_ff[i] == fcdma_pkg::MODE_REPEAT)) ?
               rld_cnt_ff[i] : cnt_ff[i];
      ready[i] = pend_ff[i] & en[i] &
                 (eff[i] != fcdma_pkg::RST_CNT);
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < fcdma_pkg::NCH; i++) begin
      nxt_src[i] = src_ff[i];
      nxt_dst[i] = dst_ff[i];
      nxt_rld_ptr[i] = rld_ptr_ff[i];
      nxt_cnt[i] = cnt_ff[i];
      nxt_rld_cnt[i] = rld_cnt_ff[i];
      nxt_code[i] = code_ff[i];
      nxt_mode[i] = mode_ff[i];
      nxt_pend[i] = pend_ff[i];
      nxt_wide[i] = wide_ff[i];
      nxt_dinc[i] = dinc_ff[i];
      nxt_irq[i] = done & (cur_ff == 2'(i)) &
                   (eff[i] == fcdma_pkg::CNT_ONE);
      if (done && cur_ff == 2'(i)) begin
        if (dinc_ff[i]) begin
          nxt_dst[i] = dst_ff[i] + unit_step(wide_ff[i]);
        end else begin
          nxt_src[i] = src_ff[i] + unit_step(wide_ff[i]);
        end
        nxt_cnt[i] = eff[i] - fcdma_pkg::CNT_ONE;
        if (eff[i] == fcdma_pkg::CNT_ONE &&
            mode_ff[i] == fcdma_pkg::MODE_REPEAT) begin
          nxt_cnt[i] = rld_cnt_ff[i];
          if (dinc_ff[i]) begin
            nxt_dst[i] = rld_ptr_ff[i];
          end else begin
            nxt_src[i] = rld_ptr_ff[i];
          end
        end
      end
      // A software write in the same cycle as a completion wins.
      if (reg_wr && wch == 2'(i)) begin
        case (wreg)
          fcdma_pkg::REG_SRC: nxt_src[i] = reg_wdata[23:0];
          fcdma_pkg::REG_DST: nxt_dst[i] = reg_wdata[23:0];
          fcdma_pkg::REG_RLD_PTR: nxt_rld_ptr[i] = reg_wdata[23:0];
          fcdma_pkg::REG_CNT: nxt_cnt[i] = reg_wdata[15:0];
          fcdma_pkg::REG_RLD_CNT: nxt_rld_cnt[i] = reg_wdata[15:0];
          fcdma_pkg::REG_SEL: nxt_code[i] = reg_wdata[4:0];
          fcdma_pkg::REG_MODE: begin
            nxt_mode[i] = reg_wdata[1:0];
            nxt_wide[i] = reg_wdata[fcdma_pkg::MODE_WIDE_BIT];
            nxt_dinc[i] = reg_wdata[fcdma_pkg::MODE_DINC_BIT];
          end
          default: nxt_code[i] = code_ff[i];
        endcase
      end
      if (take && pick == 2'(i)) begin
        nxt_pend[i] = 1'b0;
      end
      // A request in the grant cycle is kept, not lost.
      if (hit[i] && en[i]) begin
        nxt_pend[i] = 1'b1;
      end
      // A request that meets an empty count must not start a transfer
      // later, when software loads a new count.
      if (eff[i] == fcdma_pkg::RST_CNT) begin
        nxt_pend[i] = 1'b0;
      end
      if (reg_wr && wch == 2'(i) && wreg == fcdma_pkg::REG_MODE &&
          reg_wdata[1:0] == fcdma_pkg::MODE_OFF) begin
        nxt_pend[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < fcdma_pkg::NCH; i++) begin
        src_ff[i] <= fcdma_pkg::RST_ADDR;
        dst_ff[i] <= fcdma_pkg::RST_ADDR;
        rld_ptr_ff[i] <= fcdma_pkg::RST_ADDR;
        cnt_ff[i] <= fcdma_pkg::RST_CNT;
        rld_cnt_ff[i] <= fcdma_pkg::RST_CNT;
        code_ff[i] <= fcdma_pkg::CODE_SW;
        mode_ff[i] <= fcdma_pkg::MODE_OFF;
      end
      pend_ff <= 4'h0;
      wide_ff <= 4'h0;
      dinc_ff <= 4'h0;
      irq_ff <= 4'h0;
    end else begin
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
      rld_ptr_ff <= nxt_rld_ptr;
      cnt_ff <= nxt_cnt;
      rld_cnt_ff <= nxt_rld_cnt;
      code_ff <= nxt_code;
      mode_ff <= nxt_mode;
      pend_ff <= nxt_pend;
      wide_ff <= nxt_wide;
      dinc_ff <= nxt_dinc;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Read, write and a closing cycle give at least three cycles.
  always_comb begin
    nxt_state = state_ff;
    nxt_mem = mem_ff;
    case (state_ff)
      fcdma_pkg::ST_IDLE: begin
        if (take) begin
          nxt_state = fcdma_pkg::ST_READ;
          nxt_mem.addr = src_ff[pick];
          nxt_mem.rd = 1'b1;
          nxt_mem.wide = wide_ff[pick];
        end
      end
      fcdma_pkg::ST_READ: begin
        if (mem_ack) begin
          nxt_state = fcdma_pkg::ST_WRITE;
          nxt_mem.rd = 1'b0;
          nxt_mem.wr = 1'b1;
          nxt_mem.addr = dst_ff[cur_ff];
          nxt_mem.wdata = mem_ff.wide ? mem_rdata :
                          {8'h00, mem_rdata[7:0]};
        end
      end
      fcdma_pkg::ST_WRITE: begin
        if (mem_ack) begin
          nxt_state = fcdma_pkg::ST_PAD;
          nxt_mem.wr = 1'b0;
        end
      end
      fcdma_pkg::ST_PAD: nxt_state = fcdma_pkg::ST_HOLD;
      fcdma_pkg::ST_HOLD: begin
        if (cpu_access_done) begin
          nxt_state = fcdma_pkg::ST_IDLE;
        end
      end
      default: nxt_state = fcdma_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= fcdma_pkg::ST_IDLE;
      mem_ff <= '0;
      cur_ff <= 2'h0;
      pin_prev_ff <= 4'hf;
      ir_set_ff <= 22'h000000;
    end else begin
      state_ff <= nxt_state;
      mem_ff <= nxt_mem;
      cur_ff <= take ? pick : cur_ff;
      pin_prev_ff <= ext_irq_pin;
      ir_set_ff <= periph_req;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h00000000;
    case (wreg)
      fcdma_pkg::REG_SRC: rd_val = {8'h00, src_ff[wch]};
      fcdma_pkg::REG_DST: rd_val = {8'h00, dst_ff[wch]};
      fcdma_pkg::REG_RLD_PTR: rd_val = {8'h00, rld_ptr_ff[wch]};
      fcdma_pkg::REG_CNT: rd_val = {16'h0000, cnt_ff[wch]};
      fcdma_pkg::REG_RLD_CNT: rd_val = {16'h0000, rld_cnt_ff[wch]};
      fcdma_pkg::REG_SEL: rd_val = {25'h0000000, pend_ff[wch], 1'b0,
                                    code_ff[wch]};
      fcdma_pkg::REG_MODE: rd_val = {28'h0000000, dinc_ff[wch],
                                     wide_ff[wch], mode_ff[wch]};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= reg_rd ? rd_val : 32'h00000000;
    end
  end

  assign reg_rdata = rdata_ff;
  assign mem_req = mem_ff;
  assign dma_irq = irq_ff;
  assign periph_ir_set = ir_set_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] busy_cnt_ff;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_ff <= 4'h0;
    end else if (take) begin
      busy_cnt_ff <= 4'h0;
    end else if (state_ff != fcdma_pkg::ST_IDLE &&
                 state_ff != fcdma_pkg::ST_HOLD && busy_cnt_ff != 4'hf) begin
      busy_cnt_ff <= busy_cnt_ff + 4'h1;
    end
  end

  property p_prio;
    @(posedge clock) disable iff (!rstn)
      take |-> ((ready & ((4'h1 << pick) - 4'h1)) == 4'h0);
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower channel served before a ready higher one");

  property p_pend_clr;
    @(posedge clock) disable iff (!rstn)
      (take && !hit[pick]) |=> !pend_ff[$past(pick)];
  endproperty
  a_pend_clr: assert property (p_pend_clr)
    else $error("pending flag survived bus grant");

  property p_irq_cause;
    @(posedge clock) disable iff (!rstn)
      (dma_irq != 4'h0) |-> $past(done && eff_cur == 16'h0001);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("channel interrupt without count one to zero");

  property p_irq_fire;
    @(posedge clock) disable iff (!rstn)
      (done && eff_cur == 16'h0001) |=> dma_irq[$past(cur_ff)];
  endproperty
  a_irq_fire: assert property (p_irq_fire)
    else $error("count reached zero without interrupt");

  property p_min_cyc;
    @(posedge clock) disable iff (!rstn)
      done |-> (busy_cnt_ff >= 4'(fcdma_pkg::XFER_MIN_CYC - 1));
  endproperty
  a_min_cyc: assert property (p_min_cyc)
    else $error("unit finished in under three cycles");

  property p_release;
    @(posedge clock) disable iff (!rstn)
      done |=> !bus_req throughout
        (state_ff == fcdma_pkg::ST_HOLD) [*1];
  endproperty
  a_release: assert property (p_release)
    else $error("bus not released after a unit");

  property p_hold_wait;
    @(posedge clock) disable iff (!rstn)
      (state_ff == fcdma_pkg::ST_HOLD && !cpu_access_done) |=>
        (state_ff == fcdma_pkg::ST_HOLD);
  endproperty
  a_hold_wait: assert property (p_hold_wait)
    else $error("next grant before a processor access");

  property p_start_ok;
    @(posedge clock) disable iff (!rstn)
      take |-> (en[pick] && eff[pick] != 16'h0000);
  endproperty
  a_start_ok: assert property (p_start_ok)
    else $error("transfer started on disabled or empty channel");

  property p_reload;
    @(posedge clock) disable iff (!rstn)
      (done && eff_cur == 16'h0001 && !reg_wr &&
       mode_ff[cur_ff] == fcdma_pkg::MODE_REPEAT) |=>
        (cnt_ff[$past(cur_ff)] == $past(rld_cnt_ff[cur_ff]));
  endproperty
  a_reload: assert property (p_reload)
    else $error("repeat count not reloaded");

  property p_req_out;
    @(posedge clock) disable iff (!rstn)
      (state_ff == fcdma_pkg::ST_IDLE && ready != 4'h0) |-> bus_req;
  endproperty
  a_req_out: assert property (p_req_out)
    else $error("ready channel without bus request");
endmodule

/* fcdma_pkg.sv */
// Purpose: Shared constants and types for the four-channel cycle-steal DMA.
// Assumes: One clock domain and a plain register port.
// Notes:   Register index is reg_addr[2:0], channel is reg_addr[4:3].
package fcdma_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 16;
  localparam int NPERIPH = 22;
  localparam int XFER_MIN_CYC = 3;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_SRC = 3'h0;
  localparam logic [2:0] REG_DST = 3'h1;
  localparam logic [2:0] REG_RLD_PTR = 3'h2;
  localparam logic [2:0] REG_CNT = 3'h3;
  localparam logic [2:0] REG_RLD_CNT = 3'h4;
  localparam logic [2:0] REG_SEL = 3'h5;
  localparam logic [2:0] REG_MODE = 3'h6;
  localparam int SEL_SW_BIT = 5;
  localparam int SEL_PEND_BIT = 6;
  localparam int MODE_WIDE_BIT = 2;
  localparam int MODE_DINC_BIT = 3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;
  localparam logic [4:0] CODE_SW = 5'h00;
  localparam logic [4:0] CODE_FALL = 5'h01;
  localparam logic [4:0] CODE_BOTH = 5'h02;
  localparam logic [4:0] CODE_PERIPH0 = 5'h03;
  localparam logic [4:0] CODE_LAST = 5'h18;
  localparam logic [23:0] RST_ADDR = 24'h000000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_WRITE = 5'h04,
    ST_PAD = 5'h08,
    ST_HOLD = 5'h10
  } fcdma_state_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic wide;
  } fcdma_mem_t;
endpackage

/* fcdma_bus_model.sv */
// Purpose: Arbiter, memory and processor stand-in for the DMA bench.
// Assumes: One clock; memory contents are a fixed function of address.
// Notes:   With slow set, grants and acknowledges come after random stalls.
`timescale 1ns/100ps
module fcdma_bus_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow,
  input wire logic bus_req,
  output logic bus_gnt,
  input wire fcdma_pkg::fcdma_mem_t mem_req,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic cpu_access_done
);
  // ----------------------------------------------------------------
  // Grant, memory answer and processor access
  // ----------------------------------------------------------------
  logic [1:0] wait_ff;
  logic [2:0] done_ff;
  logic busy;
  logic [15:0] word;
  assign busy = mem_req.rd | mem_req.wr;
  assign word = {mem_req.addr[7:0] ^ 8'h3c, mem_req.addr[15:8]};
  // Outside the acknowledge cycle the lines carry the inverse, so a late
  // sample cannot pass by luck.
  assign mem_rdata = mem_ack ? word : ~word;
  assign cpu_access_done = (done_ff == 3'h1);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_gnt <= 1'b0;
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
      done_ff <= 3'h0;
    end else begin
      bus_gnt <= bus_req && (bus_gnt || !slow || $urandom_range(1, 0) == 1);
      mem_ack <= busy && !mem_ack && wait_ff == 2'h0;
      if (busy && !mem_ack && wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else begin
        wait_ff <= slow ? 2'($urandom_range(3, 0)) : 2'h0;
      end
      if (mem_req.wr && mem_ack) begin
        done_ff <= slow ? 3'h4 : 3'h2;
      end else if (done_ff != 3'h0) begin
        done_ff <= done_ff - 3'h1;
      end
    end
  end
endmodule

/* fcdma_tb.sv */
// Purpose: Self-checking bench for the four-channel cycle-steal DMA.
// Assumes: Register map and transfer walk of the package and hand-over.
// Notes:   Queues predict every unit; a bus monitor checks each one.
`timescale 1ns/100ps
module fcdma_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] ext_irq_pin = 4'hf;
  logic [21:0] periph_req = 22'h0;
  logic [21:0] periph_ir_set;
  logic bus_req, bus_gnt, cpu_access_done, mem_ack;
  logic slow = 1'b0;
  logic [15:0] mem_rdata;
  logic [3:0] dma_irq;
  fcdma_pkg::fcdma_mem_t mem_req;
  int num_errors = 0;
  int num_checks = 0;
  logic [23:0] m_src[4], m_dst[4], m_rp[4];
  logic [15:0] m_cnt[4], m_rld[4];
  logic [3:0] m_mode[4];
  int irq_exp[4] = '{0, 0, 0, 0};
  int irq_seen[4] = '{0, 0, 0, 0};
  logic [23:0] q_ra[$], q_wa[$];
  logic [15:0] q_wd[$];
  logic [31:0] rnd;

  always #2 clock = ~clock;

  fcdma_top dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
    .periph_req(periph_req), .periph_ir_set(periph_ir_set),
    .bus_req(bus_req), .bus_gnt(bus_gnt),
    .cpu_access_done(cpu_access_done), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dma_irq(dma_irq));

  fcdma_bus_model partner (.clock(clock), .rstn(rstn), .slow(slow),
    .bus_req(bus_req), .bus_gnt(bus_gnt), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .cpu_access_done(cpu_access_done));

  // ----------------------------------------------------------------
  // Checking, register access and reference model
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input int ch, input logic [2:0] ix, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= {2'(ch), ix};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input int ch, input logic [2:0] ix, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= {2'(ch), ix};
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask

  // Pushes one predicted unit and steps the channel's counters.
  task automatic unit(input int ch);
    logic [15:0] d;
    logic [23:0] st;
    st = m_mode[ch][2] ? 24'h2 : 24'h1;
    d = {m_src[ch][7:0] ^ 8'h3c, m_src[ch][15:8]};
    q_ra.push_back(m_src[ch]);
    q_wa.push_back(m_dst[ch]);
    q_wd.push_back(m_mode[ch][2] ? d : {8'h00, d[7:0]});
    if (m_mode[ch][3]) begin
      m_dst[ch] += st;
    end else begin
      m_src[ch] += st;
    end
    m_cnt[ch] -= 16'h1;
    if (m_cnt[ch] == 16'h0) begin
      irq_exp[ch]++;
      if (m_mode[ch][1:0] == fcdma_pkg::MODE_REPEAT) begin
        m_cnt[ch] = m_rld[ch];
        if (m_mode[ch][3]) begin
          m_dst[ch] = m_rp[ch];
        end else begin
          m_src[ch] = m_rp[ch];
        end
      end
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (q_wa.size() != 0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check(32'(q_wa.size()), 32'h0);
    repeat (12) @(posedge clock);
  endtask

  task automatic trig(input int ch);
    wr(ch, fcdma_pkg::REG_SEL, 32'(1) << fcdma_pkg::SEL_SW_BIT);
    if ((m_mode[ch][1:0] == fcdma_pkg::MODE_SINGLE ||
         m_mode[ch][1:0] == fcdma_pkg::MODE_REPEAT) && m_cnt[ch] != 0) begin
      unit(ch);
    end
    settle();
  endtask

  task automatic cfg(input int ch, input logic [23:0] s, input logic [23:0] d,
                     input logic [15:0] c, input logic [15:0] r,
                     input logic [4:0] code, input logic [3:0] md);
    m_src[ch] = s;
    m_dst[ch] = d;
    m_rp[ch] = md[3] ? d : s;
    m_cnt[ch] = c;
    m_rld[ch] = r;
    m_mode[ch] = md;
    wr(ch, fcdma_pkg::REG_SRC, {8'h0, s});
    wr(ch, fcdma_pkg::REG_DST, {8'h0, d});
    wr(ch, fcdma_pkg::REG_RLD_PTR, {8'h0, m_rp[ch]});
    wr(ch, fcdma_pkg::REG_CNT, {16'h0, c});
    wr(ch, fcdma_pkg::REG_RLD_CNT, {16'h0, r});
    wr(ch, fcdma_pkg::REG_SEL, {27'h0, code});
    wr(ch, fcdma_pkg::REG_MODE, {28'h0, md});
  endtask

  // Sampled mid-cycle so registered outputs have long settled.
  always @(negedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (dma_irq[i] === 1'b1) begin
        irq_seen[i]++;
      end
    end
    if (rstn && mem_ack === 1'b1 && mem_req.rd === 1'b1) begin
      if (q_ra.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check({8'h0, mem_req.addr}, {8'h0, q_ra.pop_front()});
      end
    end
    if (rstn && mem_ack === 1'b1 && mem_req.wr === 1'b1) begin
      if (q_wa.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check({8'h0, mem_req.addr}, {8'h0, q_wa.pop_front()});
        check({16'h0, mem_req.wdata}, {16'h0, q_wd.pop_front()});
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rnd = $urandom(32'h9dcd);
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      for (int ix = 0; ix < 8; ix++) begin
        rd(ch, 3'(ix), 32'h0);
      end
    end
    wr(2, 3'h7, 32'hffffffff);
    rd(2, 3'h7, 32'h0);
    wr(2, fcdma_pkg::REG_CNT, 32'hffffffff);
    rd(2, fcdma_pkg::REG_CNT, 32'h0000ffff);
    rnd = $urandom();
    cfg(0, rnd[23:0], 24'h001000, 16'h3, 16'h0, 5'h0, 4'h1);
    repeat (4) trig(0);
    rd(0, fcdma_pkg::REG_SRC, {8'h0, m_src[0]});
    slow <= 1'b1;
    cfg(3, 24'h000400, 24'h003000, 16'h2, 16'h2, 5'h0, 4'hf);
    repeat (5) trig(3);
    rd(3, fcdma_pkg::REG_DST, {8'h0, m_dst[3]});
    rd(3, fcdma_pkg::REG_SRC, 32'h400);
    slow <= 1'b0;
    cfg(2, rnd[23:0] ^ 24'h00f0f0, 24'h004000, 16'h1, 16'h0, 5'h0, 4'h3);
    repeat (2) trig(2);
    cfg(1, 24'h000800, 24'h005000, 16'h5, 16'h0, 5'h0, 4'h1);
    wr(1, fcdma_pkg::REG_MODE, 32'h0);
    m_mode[1] = 4'h0;
    trig(1);
    rd(1, fcdma_pkg::REG_CNT, 32'h5);
    cfg(0, 24'h000100, 24'h006000, 16'h2, 16'h0, 5'h2, 4'h1);
    for (int ch = 1; ch < 4; ch++) begin
      cfg(ch, 24'(ch * 512), 24'h006100, 16'h1, 16'h0, 5'h1, 4'h1);
    end
    @(posedge clock);
    // Fast interrupts are never used here, so all four channels may run.
    ext_irq_pin <= 4'h0;
    for (int ch = 0; ch < 4; ch++) begin
      unit(ch);
    end
    settle();
    @(posedge clock);
    ext_irq_pin <= 4'hf;
    unit(0);
    settle();
    cfg(1, rnd[23:0], 24'h007000, 16'd22, 16'h0, 5'h3, 4'h1);
    for (int k = 3; k <= 24; k++) begin
      wr(1, fcdma_pkg::REG_SEL, 32'(k));
      @(posedge clock);
      periph_req <= 22'h1 << (k - 3);
      @(posedge clock);
      periph_req <= 22'h0;
      #1;
      check({10'h0, periph_ir_set}, {10'h0, 22'h1 << (k - 3)});
      unit(1);
      settle();
    end
    for (int ch = 0; ch < 4; ch++) begin
      check(irq_seen[ch], irq_exp[ch]);
      rd(ch, fcdma_pkg::REG_CNT, {16'h0, m_cnt[ch]});
    end
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end
endmodule
